// *** verilog/amdc_core.sv ***
/*
 * Mod_depth_target_control calibration: register file on classic Wishbone,
 * calibration sequencer with successive-approximation search over the
 * eight binary-weighted driver segments, and the driver segment output.
 * Assumes an external A/D converter that answers a start pulse with a
 * done pulse and an 8-bit amplitude, and a framer that drives mod_on_i.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Source select bit 0 means calibration command makes the modulated level.
// - Depth control bits six to one hold the six-bit target ratio fraction.
// - Target equals reference amplitude divided by one plus fraction over 64.
// - Calibration first enables the transmitter at the unmodulated level.
// - Reference amplitude is measured and stored in the converter register.
// - Target level is computed before any driver adjustment starts.
// - Driver strength is found by successive approximation nearest the target.
// - Final setting goes to the display register and sets the modulated level.
// - Each driver has eight binary-weighted segments; normal level may thin them.
// - Modulated level comes only from raising both driver output resistances.
// - Source select bit 1 takes the modulated level from a software register.
// - One modulation type bit selects on-off keying or AM.
module amdc_core
    import amdc_pkg::*;
#(
    parameter int SEG_N = 8,
    parameter int SETTLE_CYC = AMDC_TX_SETTLE_CYC
) (
    input wire logic clk_i,                   // 50 MHz system clock
    input wire logic rst_i,                   // Synchronous reset, high
    input wire logic ce_i,                    // Clock enable, low freezes
    input wire logic wb_cyc_i,                // Wishbone cycle
    input wire logic wb_stb_i,                // Wishbone strobe
    input wire logic wb_we_i,                 // Wishbone write
    input wire logic [7:0] wb_adr_i,          // Byte address
    input wire logic [3:0] wb_sel_i,          // Byte lanes
    input wire logic [31:0] wb_dat_i,         // Write data
    output logic [31:0] wb_dat_o,             // Read data
    output logic wb_ack_o,                    // Acknowledge
    input wire logic mod_on_i,                // Framer asks for modulated state
    input wire logic adc_done_i,              // Converter result valid pulse
    input wire logic [7:0] adc_data_i,        // Sensed amplitude
    output logic adc_start_o,                 // Converter start pulse
    output logic tx_enable_o,                 // Transmitter on
    output logic [SEG_N-1:0] antenna_driver_out_a_o, // Segment enables, 1 = on
    output logic [SEG_N-1:0] antenna_driver_out_b_o, // Segment enables, 1 = on
    output logic busy_o                       // Sequencer running
);

    // Register state
    logic [7:0] depth_ctrl_q;
    logic [SEG_N-1:0] normal_lvl_q;
    logic [SEG_N-1:0] am_lvl_q;
    logic [SEG_N-1:0] display_q;
    logic [7:0] adc_out_q;
    logic modulation_type_select_q;
    logic tx_sw_q;
    logic [31:0] rdata_q;
    logic ack_q;

    // Sequencer state
    amdc_state_t state_q;
    amdc_state_t state_d;
    logic [15:0] settle_q;
    logic [7:0] target_q;
    logic [SEG_N-1:0] trial_q;
    logic [SEG_N-1:0] bit_q;
    logic adc_start_q;
    logic tx_seq_q;
    logic [SEG_N-1:0] seg_a_q;
    logic [SEG_N-1:0] seg_b_q;

    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire hit_ctrl = (wb_adr_i == AMDC_OFF_DEPTH_CTRL);
    wire hit_norm = (wb_adr_i == AMDC_OFF_NORMAL_LVL);
    wire hit_am = (wb_adr_i == AMDC_OFF_AM_LVL);
    wire hit_disp = (wb_adr_i == AMDC_OFF_DISPLAY);
    wire hit_adc = (wb_adr_i == AMDC_OFF_ADC_OUT);
    wire hit_cmd = (wb_adr_i == AMDC_OFF_CMD);
    wire hit_aux = (wb_adr_i == AMDC_OFF_AUX);
    wire idle = (state_q == AMDC_IDLE);

    // Fields of the depth control register
    wire level_source_select = depth_ctrl_q[AMDC_SRC_SEL_BIT];
    wire [AMDC_FRAC_W-1:0] frac = depth_ctrl_q[AMDC_FRAC_MSB:AMDC_FRAC_LSB];
    wire target_ratio_fraction_msb = frac[AMDC_FRAC_W-1];
    wire target_ratio_fraction_lsb = frac[0];

    // Commands are taken only while idle; later ones are dropped
    wire cal_go = bus_wr & hit_cmd & idle & wb_dat_i[AMDC_CMD_CAL_BIT];
    wire meas_go = bus_wr & hit_cmd & idle & ~wb_dat_i[AMDC_CMD_CAL_BIT]
        & wb_dat_i[AMDC_CMD_MEAS_BIT];

    // Target = ref * 64 / (64 + frac): divisor 1.000000b .. 1.111111b
    wire [13:0] ref_scaled = {adc_out_q, 6'h00};
    wire [6:0] divisor = {1'b1, frac};
    wire [13:0] quotient = ref_scaled / {7'h00, divisor};

    // Trial keeps its bit while the level is still at or above target
    wire keep_bit = (adc_data_i >= target_q);

    // Level code in force: higher code means more segments off
    wire [SEG_N-1:0] mod_code = level_source_select ? am_lvl_q : display_q;
    wire [SEG_N-1:0] unmod_code = normal_lvl_q;
    wire in_search = (state_q == AMDC_TRIAL) | (state_q == AMDC_TRIAL_MEAS);
    wire [SEG_N-1:0] seg_ook = {SEG_N{1'b0}};
    wire [SEG_N-1:0] seg_am = ~mod_code;
    wire [SEG_N-1:0] seg_mod = modulation_type_select_q ? seg_am : seg_ook;
    wire [SEG_N-1:0] seg_run = mod_on_i ? seg_mod : ~unmod_code;
    wire [SEG_N-1:0] seg_d = in_search ? ~trial_q : (idle ? seg_run : ~unmod_code);

    // Read multiplexer; unmapped offsets read as zero
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        if (hit_ctrl) begin
            rmux[7:0] = depth_ctrl_q;
        end
        if (hit_norm) begin
            rmux[SEG_N-1:0] = normal_lvl_q;
        end
        if (hit_am) begin
            rmux[SEG_N-1:0] = am_lvl_q;
        end
        if (hit_disp) begin
            rmux[SEG_N-1:0] = display_q;
        end
        if (hit_adc) begin
            rmux[7:0] = adc_out_q;
        end
        if (hit_cmd) begin
            rmux[AMDC_STAT_BUSY_BIT] = ~idle;
        end
        if (hit_aux) begin
            rmux[AMDC_AUX_AM_BIT] = modulation_type_select_q;
            rmux[AMDC_AUX_TXEN_BIT] = tx_sw_q;
        end
    end

    // Wishbone answer one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_q <= bus_req;
            rdata_q <= bus_req ? rmux : 32'h0000_0000;
        end
    end

    // Software-written registers; writes take effect with the ack edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            depth_ctrl_q <= AMDC_RST_DEPTH_CTRL;
            normal_lvl_q <= AMDC_RST_NORMAL_LVL[SEG_N-1:0];
            am_lvl_q <= AMDC_RST_AM_LVL[SEG_N-1:0];
            modulation_type_select_q <= AMDC_RST_AUX[AMDC_AUX_AM_BIT];
            tx_sw_q <= AMDC_RST_AUX[AMDC_AUX_TXEN_BIT];
        end else if (ce_i && bus_wr) begin
            if (hit_ctrl) begin
                depth_ctrl_q <= {wb_dat_i[7:1], 1'b0};
            end
            if (hit_norm) begin
                normal_lvl_q <= wb_dat_i[SEG_N-1:0];
            end
            if (hit_am) begin
                am_lvl_q <= wb_dat_i[SEG_N-1:0];
            end
            if (hit_aux) begin
                modulation_type_select_q <= wb_dat_i[AMDC_AUX_AM_BIT];
                tx_sw_q <= wb_dat_i[AMDC_AUX_TXEN_BIT];
            end
        end
    end

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            AMDC_IDLE: begin
                if (cal_go) begin
                    state_d = AMDC_TX_SETTLE;
                end else if (meas_go) begin
                    state_d = AMDC_AMP_MEAS;
                end
            end
            AMDC_TX_SETTLE: begin
                if (settle_q == 16'h0000) begin
                    state_d = AMDC_REF_MEAS;
                end
            end
            AMDC_REF_MEAS: begin
                if (adc_done_i) begin
                    state_d = AMDC_CALC;
                end
            end
            AMDC_CALC: begin
                state_d = AMDC_TRIAL;
            end
            AMDC_TRIAL: begin
                state_d = AMDC_TRIAL_MEAS;
            end
            AMDC_TRIAL_MEAS: begin
                if (adc_done_i) begin
                    state_d = (bit_q[0]) ? AMDC_FINISH : AMDC_TRIAL;
                end
            end
            AMDC_FINISH: begin
                state_d = AMDC_IDLE;
            end
            AMDC_AMP_MEAS: begin
                if (adc_done_i) begin
                    state_d = AMDC_IDLE;
                end
            end
        endcase
    end

    // Sequencer registers; transmitter held on through the whole calibration run
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= AMDC_IDLE;
            settle_q <= 16'h0000;
            tx_seq_q <= 1'b0;
        end else if (ce_i) begin
            state_q <= state_d;
            if (cal_go) begin
                settle_q <= 16'(SETTLE_CYC - 1);
                tx_seq_q <= 1'b1;
            end else if (state_q == AMDC_TX_SETTLE && settle_q != 16'h0000) begin
                settle_q <= settle_q - 16'h0001;
            end
            if (state_q == AMDC_FINISH) begin
                tx_seq_q <= 1'b0;
            end
        end
    end

    // Converter start: one pulse per measurement, reference, trial or measure command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_start_q <= 1'b0;
        end else if (ce_i) begin
            adc_start_q <= (state_q == AMDC_TX_SETTLE && settle_q == 16'h0000)
                | (state_q == AMDC_TRIAL) | meas_go;
        end
    end

    // Stored reference amplitude and computed target
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_out_q <= 8'h00;
            target_q <= 8'h00;
        end else if (ce_i) begin
            if (adc_done_i && (state_q == AMDC_REF_MEAS || state_q == AMDC_AMP_MEAS)) begin
                adc_out_q <= adc_data_i;
            end
            if (state_q == AMDC_CALC) begin
                target_q <= quotient[7:0];
            end
        end
    end

    // Successive approximation, most significant segment bit first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trial_q <= {SEG_N{1'b0}};
            bit_q <= {SEG_N{1'b0}};
        end else if (ce_i) begin
            if (state_q == AMDC_CALC) begin
                bit_q <= {1'b1, {(SEG_N-1){1'b0}}};
                trial_q <= {1'b1, {(SEG_N-1){1'b0}}};
            end else if (state_q == AMDC_TRIAL_MEAS && adc_done_i) begin
                // Drop the bit if the level fell below target, try next one
                trial_q <= (keep_bit ? trial_q : (trial_q & ~bit_q))
                    | (bit_q >> 1);
                bit_q <= bit_q >> 1;
            end
        end
    end

    // Result copied to the display register at the end of the run
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            display_q <= {SEG_N{1'b0}};
        end else if (ce_i && state_q == AMDC_FINISH) begin
            display_q <= trial_q;
        end
    end

    // Both drivers get the same segment pattern: modulation only by
    // switching segments off, so amplitude drops through resistance
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seg_a_q <= {SEG_N{1'b1}};
            seg_b_q <= {SEG_N{1'b1}};
        end else if (ce_i) begin
            seg_a_q <= seg_d;
            seg_b_q <= seg_d;
        end
    end

    // Output assignments, all from flip-flops
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign adc_start_o = adc_start_q;
    assign antenna_driver_out_a_o = seg_a_q;
    assign antenna_driver_out_b_o = seg_b_q;

    // Transmitter follows software or the sequencer outside a measure-command run
    logic tx_q;
    logic busy_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (ce_i) begin
            tx_q <= tx_sw_q | tx_seq_q | (state_d != AMDC_IDLE && state_d != AMDC_AMP_MEAS);
            busy_q <= (state_d != AMDC_IDLE);
        end
    end
    assign tx_enable_o = tx_q;
    assign busy_o = busy_q;

    // Fraction end bits kept visible for debug probing
    wire unused_frac = target_ratio_fraction_msb ^ target_ratio_fraction_lsb;

endmodule
`default_nettype wire

// *** verilog/amdc_pkg.sv ***
/*
 * Package for the Mod_depth_target_control calibration block: register map,
 * field positions, reset values, command bits and timing constants.
 * Assumes a 50 MHz system clock and a 32-bit classic Wishbone bus.
 */
`default_nettype none
package amdc_pkg;
    // Register byte offsets on the Wishbone bus
    localparam logic [7:0] AMDC_OFF_DEPTH_CTRL = 8'h00;
    localparam logic [7:0] AMDC_OFF_NORMAL_LVL = 8'h04;
    localparam logic [7:0] AMDC_OFF_AM_LVL = 8'h08;
    localparam logic [7:0] AMDC_OFF_DISPLAY = 8'h0C;
    localparam logic [7:0] AMDC_OFF_ADC_OUT = 8'h10;
    localparam logic [7:0] AMDC_OFF_CMD = 8'h14;
    localparam logic [7:0] AMDC_OFF_AUX = 8'h18;

    // Depth control fields
    localparam int AMDC_SRC_SEL_BIT = 7;
    localparam int AMDC_FRAC_MSB = 6;
    localparam int AMDC_FRAC_LSB = 1;
    localparam int AMDC_FRAC_W = 6;

    // Command register bits (write) and status bit (read)
    localparam int AMDC_CMD_CAL_BIT = 0;
    localparam int AMDC_CMD_MEAS_BIT = 1;
    localparam int AMDC_STAT_BUSY_BIT = 0;

    // Auxiliary register bits
    localparam int AMDC_AUX_AM_BIT = 0;
    localparam int AMDC_AUX_TXEN_BIT = 1;

    // Reset values
    localparam logic [7:0] AMDC_RST_DEPTH_CTRL = 8'h00;
    localparam logic [7:0] AMDC_RST_NORMAL_LVL = 8'h00;
    localparam logic [7:0] AMDC_RST_AM_LVL = 8'h00;
    localparam logic [7:0] AMDC_RST_AUX = 8'h00;

    // Timing: transmitter settling before the reference measurement
    localparam int AMDC_CLK_PERIOD_NS = 20;
    localparam int AMDC_TX_SETTLE_NS = 1000;
    localparam int AMDC_TX_SETTLE_CYC =
        (AMDC_TX_SETTLE_NS + AMDC_CLK_PERIOD_NS - 1) / AMDC_CLK_PERIOD_NS;

    // Sequencer states
    typedef enum logic [2:0] {
        AMDC_IDLE,
        AMDC_TX_SETTLE,
        AMDC_REF_MEAS,
        AMDC_CALC,
        AMDC_TRIAL,
        AMDC_TRIAL_MEAS,
        AMDC_FINISH,
        AMDC_AMP_MEAS
    } amdc_state_t;
endpackage
`default_nettype wire

// *** verif/amdc_monitor.sv ***
/* Port checker for the depth calibration block.
   Assumes ce_i is held high and that SEG_N is passed on by the bind. */
`timescale 1ns/1ps
`default_nettype none
module amdc_monitor #(
    parameter int SEG_N = 8
) (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Acknowledge
    input wire logic adc_done_i, // Result pulse
    input wire logic adc_start_o, // Start pulse
    input wire logic [SEG_N-1:0] antenna_driver_out_a_o, // Segments a
    input wire logic [SEG_N-1:0] antenna_driver_out_b_o, // Segments b
    input wire logic busy_o // Sequencer busy
);
    localparam int SETTLE_MAX = 64;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // A result inside a run leads to a new trial or to the end
    sequence s_cal_result;
        busy_o && adc_done_i;
    endsequence
    sequence s_next_step;
        ##[1:6] (adc_start_o || !busy_o);
    endsequence
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_quiet_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_drivers_equal: assert property (antenna_driver_out_a_o == antenna_driver_out_b_o)
        else $error("driver outputs differ");
    a_reset_all_on: assert property ($fell(rst_i) |-> &antenna_driver_out_a_o && !busy_o)
        else $error("reset state wrong");
    a_start_one_pulse: assert property (adc_start_o |=> !adc_start_o)
        else $error("start longer than one cycle");
    a_trial_follows: assert property (s_cal_result |-> s_next_step)
        else $error("search stalled after result");
    // A measure command raises busy and start together, so zero delay is legal
    a_settle_then_meas: assert property ($rose(busy_o) |-> ##[0:SETTLE_MAX] adc_start_o)
        else $error("no measurement after start");
endmodule
bind amdc_core amdc_monitor #(.SEG_N(SEG_N)) u_mon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .adc_done_i(adc_done_i),
    .adc_start_o(adc_start_o),
    .antenna_driver_out_a_o(antenna_driver_out_a_o),
    .antenna_driver_out_b_o(antenna_driver_out_b_o),
    .busy_o(busy_o)
);
`default_nettype wire

// *** verif/amdc_adc_model.sv ***
/* Converter and antenna model: amplitude follows the segments that are on.
   Assumes the start pulse lasts one cycle; the lag input sets answer speed. */
`timescale 1ns/1ps
`default_nettype none
module amdc_adc_model (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset
    input wire logic start_i, // Conversion start
    input wire logic [7:0] seg_i, // Segments on
    input wire logic [3:0] lag_i, // Extra answer delay
    output logic done_o, // Result pulse
    output logic [7:0] data_o // Amplitude
);
    int cnt;
    // Bus toggles outside a result so a stale value is never mistaken
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        data_o <= ~data_o;
        if (rst_i) begin
            cnt <= 0;
            data_o <= 8'hA5;
        end else if (start_i) begin
            cnt <= int'(lag_i) + 1;
        end else if (cnt == 1) begin
            done_o <= 1'b1;
            data_o <= seg_i;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
/* Self-checking bench: Wishbone register tests, calibration runs, level select.
   Assumes the oscillator and regulators are up, as the host must ensure. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    import amdc_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mod_on = 0, done, ack, start, tx, busy;
    logic [7:0] adr = 0, adc_d, seg_a;
    logic [3:0] sel = 0, lag = 0;
    logic [31:0] wdat = 0, rdat, rd;
    logic [7:0] ctl [3] = '{8'h00, 8'h1C, 8'h7E};
    logic [7:0] offs [5] = '{AMDC_OFF_DEPTH_CTRL, AMDC_OFF_NORMAL_LVL, AMDC_OFF_AM_LVL,
        AMDC_OFF_AUX, 8'h1C};
    logic [7:0] exp_code;
    int n_fail = 0, tests_run = 0, starts = 0;
    always #10 clk_i = ~clk_i;
    amdc_core #(.SETTLE_CYC(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .mod_on_i(mod_on),
        .adc_done_i(done), .adc_data_i(adc_d), .adc_start_o(start), .tx_enable_o(tx),
        .antenna_driver_out_a_o(seg_a), .antenna_driver_out_b_o(), .busy_o(busy));
    amdc_adc_model u_adc (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .seg_i(seg_a),
        .lag_i(lag), .done_o(done), .data_o(adc_d));
    // Every measurement needs the transmitter on
    always @(posedge clk_i) begin
        if (start) begin
            starts++;
            `CHK(tx, 1'b1)
        end
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        // Request held until ack is sampled high; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hF);
        `CHK(rd, e)
    endtask
    // Bounded wait; a short floor covers commands that never show busy
    task automatic wait_idle();
        for (int k = 0; k < 400 && (k < 12 || busy); k++) @(posedge clk_i);
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK(seg_a, 8'hFF)
        for (int i = 0; i < 5; i++) rdchk(offs[i], 32'h0);
        wb(1'b1, AMDC_OFF_DEPTH_CTRL, 32'hFF, 4'hF);
        rdchk(AMDC_OFF_DEPTH_CTRL, 32'hFE);
        wb(1'b1, AMDC_OFF_DEPTH_CTRL, 32'h0, 4'h0);
        rdchk(AMDC_OFF_DEPTH_CTRL, 32'hFE);
        wb(1'b1, AMDC_OFF_AUX, 32'h2, 4'hF);
        wb(1'b1, AMDC_OFF_NORMAL_LVL, 32'h0F, 4'hF);
        rdchk(AMDC_OFF_NORMAL_LVL, 32'h0F);
        `CHK(seg_a, 8'hF0)
        wb(1'b1, AMDC_OFF_CMD, 32'h2, 4'hF);
        wait_idle();
        rdchk(AMDC_OFF_ADC_OUT, 32'hF0);
        wb(1'b1, AMDC_OFF_NORMAL_LVL, 32'h0, 4'hF);
        // Three depths, each at a different converter speed
        for (int i = 0; i < 3; i++) begin
            lag <= 4'(i * 5);
            exp_code = 8'(255 - 16320 / (64 + int'(ctl[i][6:1])));
            wb(1'b1, AMDC_OFF_DEPTH_CTRL, {24'h0, ctl[i]}, 4'hF);
            starts = 0;
            wb(1'b1, AMDC_OFF_CMD, 32'h1, 4'hF);
            wb(1'b1, AMDC_OFF_CMD, 32'h1, 4'hF);
            rdchk(AMDC_OFF_CMD, 32'h1);
            wait_idle();
            `CHK(starts, 9)
            rdchk(AMDC_OFF_ADC_OUT, 32'hFF);
            rdchk(AMDC_OFF_DISPLAY, {24'h0, exp_code});
            wb(1'b1, AMDC_OFF_AUX, 32'h3, 4'hF);
            mod_on <= 1'b1;
            rdchk(AMDC_OFF_AUX, 32'h3);
            `CHK(seg_a, ~exp_code)
            mod_on <= 1'b0;
            wb(1'b1, AMDC_OFF_AUX, 32'h2, 4'hF);
        end
        wb(1'b1, AMDC_OFF_DISPLAY, 32'h55, 4'hF);
        rdchk(AMDC_OFF_DISPLAY, {24'h0, exp_code});
        wb(1'b1, AMDC_OFF_AM_LVL, 32'h3C, 4'hF);
        wb(1'b1, AMDC_OFF_DEPTH_CTRL, 32'h80, 4'hF);
        wb(1'b1, AMDC_OFF_AUX, 32'h3, 4'hF);
        mod_on <= 1'b1;
        rdchk(AMDC_OFF_AM_LVL, 32'h3C);
        `CHK(seg_a, 8'hC3)
        wb(1'b1, AMDC_OFF_AUX, 32'h2, 4'hF);
        rdchk(AMDC_OFF_AUX, 32'h2);
        `CHK(seg_a, 8'h00)
        // Host-run search, deeper than the built-in divisor reaches: target 8'h78
        mod_on <= 1'b0;
        wb(1'b1, AMDC_OFF_NORMAL_LVL, 32'h0, 4'hF);
        wb(1'b1, AMDC_OFF_CMD, 32'h2, 4'hF);
        wait_idle();
        rdchk(AMDC_OFF_ADC_OUT, 32'hFF);
        exp_code = 8'h00;
        for (int b = 7; b >= 0; b--) begin
            wb(1'b1, AMDC_OFF_NORMAL_LVL, {24'h0, exp_code | 8'(1 << b)}, 4'hF);
            wb(1'b1, AMDC_OFF_CMD, 32'h2, 4'hF);
            wait_idle();
            wb(1'b0, AMDC_OFF_ADC_OUT, 32'h0, 4'hF);
            if (rd[7:0] >= 8'h78) begin
                exp_code = exp_code | 8'(1 << b);
            end
        end
        `CHK(exp_code, 8'h87)
        wb(1'b1, AMDC_OFF_AM_LVL, {24'h0, exp_code}, 4'hF);
        wb(1'b1, AMDC_OFF_NORMAL_LVL, 32'h0, 4'hF);
        wb(1'b1, AMDC_OFF_AUX, 32'h3, 4'hF);
        mod_on <= 1'b1;
        rdchk(AMDC_OFF_NORMAL_LVL, 32'h0);
        `CHK(seg_a, 8'h78)
        end_of_test();
    end
endmodule
`default_nettype wire
